// ===== verilog/accirq_regs.sv
`include "accirq_consts.svh"

module accirq_regs
   import accirq_pkg::*;
#(
   parameter int FILL_W = 6, // queue fill count width
   parameter int LEVEL_W = 5 // queue threshold width
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wr_data,
   input wire logic reg_rd_en,
   output logic [7:0] reg_rd_data,
   output logic reg_rd_valid,
   // mode controls held elsewhere in the device
   input wire logic word_coherent_update,
   input wire logic event_latch_select,
   input wire logic pad_polarity_select,
   input wire logic low_power_one,
   input wire logic rate_is_1600,
   // detection engine events, one-cycle pulses
   input wire logic orient_evt,
   input wire logic onetap_evt,
   input wire logic twotap_evt,
   input wire logic wake_evt,
   input wire logic freefall_evt,
   input wire logic sleep_change_evt,
   input wire logic newdata_evt,
   input wire logic temp_newdata_evt,
   // levels from the device
   input wire logic sleep_state,
   input wire logic boot_state,
   input wire logic queue_overrun,
   input wire logic [FILL_W-1:0] queue_fill,
   input wire logic [LEVEL_W-1:0] queue_threshold,
   // samples
   input wire logic [7:0] temp_sample,
   input wire logic sample_valid,
   input wire logic [15:0] sample_x,
   input wire logic [15:0] sample_y,
   // interrupt pads
   output logic event_pad_one,
   output logic event_pad_two,
   // filter controls
   output logic [1:0] cutoff_select,
   output logic [1:0] range_select,
   output logic filter_path_select,
   output logic low_noise_en,
   output logic [4:0] cutoff_div,
   output logic cutoff_cap_400
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   accirq_byte_type pad1_route_r; // pad one routing bits
   accirq_byte_type pad2_route_r; // pad two routing bits
   accirq_byte_type filt_ctrl_r; // filter control, low two bits unused
   accirq_byte_type temp_r; // last temperature sample
   logic temp_ready_r; // temperature sample unread
   logic wake_flag_r; // wakeup seen
   logic twotap_flag_r; // double tap seen
   logic onetap_flag_r; // single tap seen
   logic orient_flag_r; // orientation change seen
   logic freefall_flag_r; // free-fall seen
   logic newdata_flag_r; // fresh x/y data
   logic queue_level_flag_r; // fill at or above threshold
   logic queue_full_r; // queue holds its full count
   logic sleep_flag_r; // sleep state seen
   logic status_read; // status byte read now
   logic axis_read; // any axis byte read now
   logic temp_read; // temperature byte read now
   logic local_sel_r; // answer comes from this module
   logic rd_pend_r; // read in first stage
   accirq_byte_type local_data_r; // first-stage local answer
   accirq_byte_type status_byte; // assembled status
   accirq_byte_type pad1_src; // pad one sources in routing order
   accirq_byte_type pad2_src; // pad two sources in routing order
   logic [FILL_W-1:0] threshold_wide; // threshold at fill width

   accirq_axis_if ax (); // link to axis holder

   // read strobe for one address, used by several side effects
   function automatic logic rd_hit(input logic en, input logic [7:0] a,
                                   input logic [7:0] want);
      rd_hit = en && (a == want);
   endfunction : rd_hit

   // divider of the output rate for a bandwidth code
   function automatic logic [4:0] div_of(input accirq_cut_type code);
      case (code)
         2'h0: div_of = `ACCIRQ_DIV_CODE0;
         2'h1: div_of = `ACCIRQ_DIV_CODE1;
         2'h2: div_of = `ACCIRQ_DIV_CODE2;
         default: div_of = `ACCIRQ_DIV_CODE3;
      endcase
   endfunction : div_of

   assign status_read = rd_hit(reg_rd_en, reg_addr, `ACCIRQ_ADDR_STATUS);
   assign temp_read = rd_hit(reg_rd_en, reg_addr, `ACCIRQ_ADDR_TEMP);
   assign axis_read = reg_rd_en && (reg_addr >= `ACCIRQ_ADDR_X_LO)
                      && (reg_addr <= `ACCIRQ_ADDR_Y_HI);
   assign threshold_wide = FILL_W'(queue_threshold);

   ////////////////////////////////////////////////////////////////////////////
   // writable registers; routing bits clear at reset
   always_ff @(posedge clk) begin
      if (srst) begin
         pad1_route_r <= `ACCIRQ_RST_BYTE;
         pad2_route_r <= `ACCIRQ_RST_BYTE;
         filt_ctrl_r <= `ACCIRQ_RST_BYTE;
      end else if (reg_wr_en) begin
         case (reg_addr)
            `ACCIRQ_ADDR_PAD1: pad1_route_r <= reg_wr_data;
            `ACCIRQ_ADDR_PAD2: pad2_route_r <= reg_wr_data;
            // unused low bits are dropped so they cannot steer anything
            `ACCIRQ_ADDR_FILT: filt_ctrl_r <= reg_wr_data & `ACCIRQ_FILT_KEEP;
            default: ; // read-only and unmapped addresses ignore writes
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // filter controls out of the control byte
   always_ff @(posedge clk) begin
      if (srst) begin
         cutoff_select <= 2'h0;
         range_select <= 2'h0;
         filter_path_select <= 1'b0;
         low_noise_en <= 1'b0;
         cutoff_div <= `ACCIRQ_DIV_CODE0;
         cutoff_cap_400 <= 1'b0;
      end else begin
         cutoff_select <= filt_ctrl_r[`ACCIRQ_CUT_HI:`ACCIRQ_CUT_LO];
         range_select <= filt_ctrl_r[`ACCIRQ_RANGE_HI:`ACCIRQ_RANGE_LO];
         filter_path_select <= filt_ctrl_r[`ACCIRQ_PATH_BIT];
         low_noise_en <= filt_ctrl_r[`ACCIRQ_NOISE_BIT];
         cutoff_div <= div_of(filt_ctrl_r[`ACCIRQ_CUT_HI:`ACCIRQ_CUT_LO]);
         // the half-rate cutoff cannot exceed 400 Hz at the top rate
         cutoff_cap_400 <= (filt_ctrl_r[`ACCIRQ_CUT_HI:`ACCIRQ_CUT_LO] == 2'h0)
                           && rate_is_1600;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // temperature byte, already scaled one count per degree around 25C
   always_ff @(posedge clk) begin
      if (srst) begin
         temp_r <= `ACCIRQ_RST_BYTE;
      end else if (temp_newdata_evt) begin
         temp_r <= temp_sample;
      end
   end

   // temperature ready: set wins over the read that clears it
   always_ff @(posedge clk) begin
      if (srst) begin
         temp_ready_r <= 1'b0;
      end else begin
         temp_ready_r <= temp_newdata_evt || (temp_ready_r && !temp_read);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // event flags: pulsed mode follows the event, latched mode holds it
   // until the status byte is read; a new event beats the clear
   always_ff @(posedge clk) begin
      if (srst) begin
         wake_flag_r <= 1'b0;
         twotap_flag_r <= 1'b0;
         onetap_flag_r <= 1'b0;
         orient_flag_r <= 1'b0;
         freefall_flag_r <= 1'b0;
      end else begin
         wake_flag_r <= wake_evt
            || (event_latch_select && wake_flag_r && !status_read);
         twotap_flag_r <= twotap_evt
            || (event_latch_select && twotap_flag_r && !status_read);
         onetap_flag_r <= onetap_evt
            || (event_latch_select && onetap_flag_r && !status_read);
         orient_flag_r <= orient_evt
            || (event_latch_select && orient_flag_r && !status_read);
         freefall_flag_r <= freefall_evt
            || (event_latch_select && freefall_flag_r && !status_read);
      end
   end

   // level flags and new data; axis reads consume the new-data flag
   always_ff @(posedge clk) begin
      if (srst) begin
         sleep_flag_r <= 1'b0;
         newdata_flag_r <= 1'b0;
         queue_level_flag_r <= 1'b0;
         queue_full_r <= 1'b0;
      end else begin
         sleep_flag_r <= sleep_state;
         newdata_flag_r <= newdata_evt || (newdata_flag_r && !axis_read);
         queue_level_flag_r <= (queue_fill >= threshold_wide);
         queue_full_r <= (queue_fill == FILL_W'(`ACCIRQ_QUEUE_FULL));
      end
   end

   always_comb begin
      status_byte = `ACCIRQ_RST_BYTE;
      status_byte[`ACCIRQ_ST_LEVEL] = queue_level_flag_r;
      status_byte[`ACCIRQ_ST_WAKE] = wake_flag_r;
      status_byte[`ACCIRQ_ST_SLEEP] = sleep_flag_r;
      status_byte[`ACCIRQ_ST_TWOTAP] = twotap_flag_r;
      status_byte[`ACCIRQ_ST_ONETAP] = onetap_flag_r;
      status_byte[`ACCIRQ_ST_ORIENT] = orient_flag_r;
      status_byte[`ACCIRQ_ST_FREEFALL] = freefall_flag_r;
      status_byte[`ACCIRQ_ST_NEWDATA] = newdata_flag_r;
   end

   ////////////////////////////////////////////////////////////////////////////
   // pad sources, bit for bit against the routing registers
   assign pad1_src = {orient_flag_r, onetap_flag_r, wake_flag_r, freefall_flag_r,
                      twotap_flag_r, queue_full_r, queue_level_flag_r, newdata_flag_r};
   assign pad2_src = {sleep_flag_r, sleep_change_evt, boot_state, temp_ready_r,
                      queue_overrun, queue_full_r, queue_level_flag_r, newdata_flag_r};

   // pads: polarity applied last so an idle pad sits at its inactive level, except in reset, which drives both pads low
   always_ff @(posedge clk) begin
      if (srst) begin
         event_pad_one <= 1'b0;
         event_pad_two <= 1'b0;
      end else begin
         event_pad_one <= (|(pad1_route_r & pad1_src)) ^ pad_polarity_select;
         event_pad_two <= (|(pad2_route_r & pad2_src)) ^ pad_polarity_select;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axis holder link
   assign ax.rd_en = reg_rd_en;
   assign ax.rd_addr = reg_addr;
   assign ax.coherent = word_coherent_update;
   assign ax.lp_one = low_power_one;
   assign ax.smp_valid = sample_valid;
   assign ax.smp_x = sample_x;
   assign ax.smp_y = sample_y;

   accirq_axis_hold u_hold (
      .clk(clk),
      .srst(srst),
      .ax(ax.hold)
   );

   ////////////////////////////////////////////////////////////////////////////
   // read first stage: local bytes, matched in time to the holder's answer
   always_ff @(posedge clk) begin
      if (srst) begin
         local_data_r <= `ACCIRQ_RST_BYTE;
         local_sel_r <= 1'b1;
         rd_pend_r <= 1'b0;
      end else begin
         rd_pend_r <= reg_rd_en;
         local_sel_r <= !axis_read;
         if (reg_rd_en) begin
            case (reg_addr)
               `ACCIRQ_ADDR_PAD1: local_data_r <= pad1_route_r;
               `ACCIRQ_ADDR_PAD2: local_data_r <= pad2_route_r;
               `ACCIRQ_ADDR_FILT: local_data_r <= filt_ctrl_r;
               `ACCIRQ_ADDR_TEMP: local_data_r <= temp_r;
               `ACCIRQ_ADDR_STATUS: local_data_r <= status_byte;
               default: local_data_r <= `ACCIRQ_RST_BYTE; // unmapped reads zero
            endcase
         end
      end
   end

   // read second stage: two cycles from request to answer for every address
   always_ff @(posedge clk) begin
      if (srst) begin
         reg_rd_data <= `ACCIRQ_RST_BYTE;
         reg_rd_valid <= 1'b0;
      end else begin
         reg_rd_valid <= rd_pend_r;
         if (rd_pend_r) begin
            reg_rd_data <= local_sel_r ? local_data_r : ax.rd_data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   chk_pad1_newdata: assert property (@(posedge clk) disable iff (srst)
      (pad1_route_r[0] && newdata_flag_r && !pad_polarity_select) |=> event_pad_one)
      else $error("pad one missed routed new data");

   chk_pad2_boot: assert property (@(posedge clk) disable iff (srst)
      (pad2_route_r[5] && boot_state && !pad_polarity_select) |=> event_pad_two)
      else $error("pad two missed routed boot state");

   chk_pad_polarity: assert property (@(posedge clk) disable iff (srst)
      (pad1_route_r == 8'h00 && pad_polarity_select) |=> event_pad_one)
      else $error("idle pad one not high under low polarity");

   chk_cutoff_div: assert property (@(posedge clk) disable iff (srst)
      (filt_ctrl_r[`ACCIRQ_CUT_HI:`ACCIRQ_CUT_LO] == 2'h2) |=> (cutoff_div == 5'h0A))
      else $error("cutoff divider wrong for code two");

   chk_filter_path: assert property (@(posedge clk) disable iff (srst)
      (reg_wr_en && reg_addr == `ACCIRQ_ADDR_FILT && reg_wr_data[3])
      |=> ##1 filter_path_select)
      else $error("high-pass path not selected");

   chk_low_noise: assert property (@(posedge clk) disable iff (srst)
      (reg_wr_en && reg_addr == `ACCIRQ_ADDR_FILT && !reg_wr_data[2])
      |=> ##1 !low_noise_en)
      else $error("low-noise stayed on");

   chk_temp_capture: assert property (@(posedge clk) disable iff (srst)
      temp_newdata_evt |=> (temp_r == $past(temp_sample)))
      else $error("temperature byte not captured");

   chk_queue_level: assert property (@(posedge clk) disable iff (srst)
      ##1 (queue_level_flag_r == ($past(queue_fill) >= $past(threshold_wide))))
      else $error("queue level flag disagrees with fill");

   chk_wake_latched: assert property (@(posedge clk) disable iff (srst)
      (wake_evt && event_latch_select) ##1 (event_latch_select && !status_read)
      |=> wake_flag_r)
      else $error("latched wake flag dropped");

   chk_tap_pulsed: assert property (@(posedge clk) disable iff (srst)
      (!onetap_evt && !event_latch_select) |=> !onetap_flag_r)
      else $error("pulsed tap flag held");

   chk_newdata_set: assert property (@(posedge clk) disable iff (srst)
      newdata_evt |=> newdata_flag_r)
      else $error("new data flag not set");

   chk_filt_zero: assert property (@(posedge clk) disable iff (srst)
      (reg_rd_en && reg_addr == `ACCIRQ_ADDR_FILT) |-> ##2 (reg_rd_data[1:0] == 2'h0))
      else $error("fixed-zero bits read nonzero");

   chk_status_read: assert property (@(posedge clk) disable iff (srst)
      (reg_rd_en && reg_addr == `ACCIRQ_ADDR_STATUS && freefall_flag_r && !freefall_evt)
      |-> ##2 (reg_rd_valid && reg_rd_data[1]))
      else $error("status read lost free-fall flag");

endmodule : accirq_regs

// ===== include/accirq_consts.svh
`ifndef ACCIRQ_CONSTS_SVH
`define ACCIRQ_CONSTS_SVH

// register addresses
`define ACCIRQ_ADDR_PAD1 8'h23
`define ACCIRQ_ADDR_PAD2 8'h24
`define ACCIRQ_ADDR_FILT 8'h25
`define ACCIRQ_ADDR_TEMP 8'h26
`define ACCIRQ_ADDR_STATUS 8'h27
`define ACCIRQ_ADDR_X_LO 8'h28
`define ACCIRQ_ADDR_X_HI 8'h29
`define ACCIRQ_ADDR_Y_LO 8'h2A
`define ACCIRQ_ADDR_Y_HI 8'h2B

// reset values
`define ACCIRQ_RST_BYTE 8'h00
`define ACCIRQ_RST_WORD 16'h0000

// filter and scale control fields
`define ACCIRQ_CUT_HI 7
`define ACCIRQ_CUT_LO 6
`define ACCIRQ_RANGE_HI 5
`define ACCIRQ_RANGE_LO 4
`define ACCIRQ_PATH_BIT 3
`define ACCIRQ_NOISE_BIT 2
`define ACCIRQ_FILT_KEEP 8'hFC

// cutoff divider per bandwidth code
`define ACCIRQ_DIV_CODE0 5'h02
`define ACCIRQ_DIV_CODE1 5'h04
`define ACCIRQ_DIV_CODE2 5'h0A
`define ACCIRQ_DIV_CODE3 5'h14

// status bit positions
`define ACCIRQ_ST_LEVEL 7
`define ACCIRQ_ST_WAKE 6
`define ACCIRQ_ST_SLEEP 5
`define ACCIRQ_ST_TWOTAP 4
`define ACCIRQ_ST_ONETAP 3
`define ACCIRQ_ST_ORIENT 2
`define ACCIRQ_ST_FREEFALL 1
`define ACCIRQ_ST_NEWDATA 0

// queue full level, and output-byte masks
`define ACCIRQ_QUEUE_FULL 6'h20
`define ACCIRQ_LO_MASK 8'hFC
`define ACCIRQ_LO_MASK_LP1 8'hF0

`endif

// ===== include/accirq_pkg.sv
package accirq_pkg;
   typedef logic [7:0] accirq_byte_type; // one register byte
   typedef logic [15:0] accirq_word_type; // one axis sample
   typedef logic [1:0] accirq_cut_type; // bandwidth code
endpackage : accirq_pkg

// ===== include/accirq_axis_if.sv
interface accirq_axis_if;
   import accirq_pkg::*;
   logic rd_en; // read request this cycle
   logic [7:0] rd_addr; // address of the read
   accirq_byte_type rd_data; // registered axis byte
   logic coherent; // hold words until both halves read
   logic lp_one; // low-power mode 1 active
   logic smp_valid; // new sample pair arriving
   accirq_word_type smp_x; // x sample
   accirq_word_type smp_y; // y sample
   modport regs (output rd_en, rd_addr, coherent, lp_one, smp_valid, smp_x, smp_y,
                 input rd_data);
   modport hold (input rd_en, rd_addr, coherent, lp_one, smp_valid, smp_x, smp_y,
                 output rd_data);
endinterface : accirq_axis_if

// ===== verilog/accirq_axis_hold.sv
`include "accirq_consts.svh"

module accirq_axis_hold
   import accirq_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // link to the register bank
   accirq_axis_if.hold ax
);

   // axis index of an address, 0 for x and 1 for y
   function automatic logic axis_of(input logic [7:0] a);
      axis_of = (a == `ACCIRQ_ADDR_Y_LO) || (a == `ACCIRQ_ADDR_Y_HI);
   endfunction : axis_of

   accirq_word_type word_r [2]; // held output words
   logic lo_seen_r [2]; // low byte read since lock
   logic hi_seen_r [2]; // high byte read since lock
   logic is_axis; // request hits an axis byte
   logic is_hi; // request hits a high byte

   assign is_axis = ax.rd_en && (ax.rd_addr >= `ACCIRQ_ADDR_X_LO)
                    && (ax.rd_addr <= `ACCIRQ_ADDR_Y_HI);
   assign is_hi = ax.rd_addr[0];

   ////////////////////////////////////////////////////////////////////////////
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_axis
         logic hit; // this axis read now
         logic lo_now; // low half seen incl. this cycle
         logic hi_now; // high half seen incl. this cycle
         assign hit = is_axis && (axis_of(ax.rd_addr) == 1'(g));
         assign lo_now = lo_seen_r[g] || (hit && !is_hi);
         assign hi_now = hi_seen_r[g] || (hit && is_hi);

         // read tracking: a lock opens on the first half and ends with the second
         always_ff @(posedge clk) begin
            if (srst || !ax.coherent || (lo_now && hi_now)) begin
               lo_seen_r[g] <= 1'b0;
               hi_seen_r[g] <= 1'b0;
            end else begin
               lo_seen_r[g] <= lo_now;
               hi_seen_r[g] <= hi_now;
            end
         end

         // word update, frozen from the first half's read edge until the second;
         // freezing on the read edge itself keeps both halves from one sample
         always_ff @(posedge clk) begin
            if (srst) begin
               word_r[g] <= `ACCIRQ_RST_WORD;
            end else if (ax.smp_valid && !(ax.coherent && (lo_now || hi_now))) begin
               word_r[g] <= (g == 0) ? ax.smp_x : ax.smp_y;
            end
         end

         chk_coherent_hold: assert property (@(posedge clk) disable iff (srst)
            (ax.coherent && lo_seen_r[g] && !hi_seen_r[g] && !hit) |=> $stable(word_r[g]))
            else $error("axis word changed while half read");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // registered byte read; low byte masks its dead bits
   always_ff @(posedge clk) begin
      if (srst) begin
         ax.rd_data <= `ACCIRQ_RST_BYTE;
      end else if (is_axis) begin
         if (is_hi) begin
            ax.rd_data <= word_r[axis_of(ax.rd_addr)][15:8];
         end else if (ax.lp_one) begin
            ax.rd_data <= word_r[axis_of(ax.rd_addr)][7:0] & `ACCIRQ_LO_MASK_LP1;
         end else begin
            ax.rd_data <= word_r[axis_of(ax.rd_addr)][7:0] & `ACCIRQ_LO_MASK;
         end
      end
   end

   chk_low_bits_zero: assert property (@(posedge clk) disable iff (srst)
      (is_axis && !is_hi) |=> (ax.rd_data[1:0] == 2'h0))
      else $error("axis low byte bits 1:0 not zero");

   chk_high_byte_word: assert property (@(posedge clk) disable iff (srst)
      (is_axis && is_hi && !axis_of(ax.rd_addr)) |=> (ax.rd_data == $past(word_r[0][15:8])))
      else $error("x high byte does not match word");

endmodule : accirq_axis_hold

// ===== tb/accirq_host_model.sv
////////////////////////////////////////////////////////////////////////////////
// host side of the register port: one request per call, strobe held one edge
module accirq_host_model (
   // clock
   input wire logic clk,
   // register port, driven by the host
   output logic [7:0] reg_addr,
   output logic reg_wr_en,
   output logic [7:0] reg_wr_data,
   output logic reg_rd_en,
   input wire logic [7:0] reg_rd_data,
   input wire logic reg_rd_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle bus at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wr_en = 1'b0;
      reg_wr_data = 8'h00;
      reg_rd_en = 1'b0;
   end
   // released fields show the inverse, so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wr_data <= d;
      reg_wr_en <= 1'b1;
      @(posedge clk);
      reg_wr_en <= 1'b0;
      reg_addr <= ~a;
      reg_wr_data <= ~d;
   endtask : wr
   // answer is looked for under a small bound, never waited on forever
   task automatic rd(input logic [7:0] a, output logic [7:0] q, output bit ok);
      int n = 0;
      ok = 1'b0;
      q = 8'h00;
      @(posedge clk);
      reg_addr <= a;
      reg_rd_en <= 1'b1;
      @(posedge clk);
      reg_rd_en <= 1'b0;
      reg_addr <= ~a;
      while (!ok && n < 4) begin
         @(posedge clk);
         #1;
         ok = (reg_rd_valid === 1'b1);
         q = reg_rd_data;
         n++;
      end
   endtask : rd
endmodule : accirq_host_model

// ===== tb/accirq_regs_tb_top.sv
`define CHK(n, e, g) begin \
   cmp_count++; \
   if ((g) !== (e)) begin \
      mismatches++; \
      $display("unexpected %s exp %h got %h", n, e, g); \
   end \
end
module accirq_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, srst, reg_wr_en, reg_rd_en, reg_rd_valid, sample_valid;
   logic [7:0] reg_addr, reg_wr_data, reg_rd_data, temp_sample, q;
   logic [7:0] ev; // temp, newdata, sleep change, freefall, wake, two, one, orient
   logic [3:0] lv; // rate, overrun, boot, sleep levels
   logic word_coherent_update, event_latch_select, pad_polarity_select, low_power_one;
   logic [5:0] queue_fill;
   logic [4:0] queue_threshold, cutoff_div;
   logic [15:0] sample_x, sample_y;
   logic event_pad_one, event_pad_two, filter_path_select, low_noise_en, cutoff_cap_400;
   logic [1:0] cutoff_select, range_select;
   int mismatches, cmp_count;
   bit ok;
   accirq_regs dut (
      .clk, .srst, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data,
      .reg_rd_valid, .word_coherent_update, .event_latch_select, .pad_polarity_select,
      .low_power_one, .rate_is_1600(lv[3]), .orient_evt(ev[0]), .onetap_evt(ev[1]),
      .twotap_evt(ev[2]), .wake_evt(ev[3]), .freefall_evt(ev[4]), .sleep_change_evt(ev[5]),
      .newdata_evt(ev[6]), .temp_newdata_evt(ev[7]), .sleep_state(lv[0]),
      .boot_state(lv[1]), .queue_overrun(lv[2]), .queue_fill, .queue_threshold,
      .temp_sample, .sample_valid, .sample_x, .sample_y, .event_pad_one, .event_pad_two,
      .cutoff_select, .range_select, .filter_path_select, .low_noise_en, .cutoff_div,
      .cutoff_cap_400);
   accirq_host_model host (.clk, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en,
      .reg_rd_data, .reg_rd_valid);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict
   // a read that never answers ends the run as a failure
   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string n);
      host.rd(a, q, ok);
      if (!ok) begin
         $display("unexpected %s exp %h got no answer", n, e);
         mismatches++;
         print_verdict();
      end else `CHK(n, e, q)
   endtask : rchk
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic pulse(input logic [7:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 8'h00;
   endtask : pulse
   // new axis pair always comes with the newdata event
   task automatic smp(input logic [15:0] x, input logic [15:0] y);
      @(posedge clk);
      sample_x <= x;
      sample_y <= y;
      sample_valid <= 1'b1;
      ev <= 8'h40;
      @(posedge clk);
      sample_valid <= 1'b0;
      ev <= 8'h00;
   endtask : smp
   ////////////////////////////////////////////////////////////////////////////////
   // reset values, every cutoff code, dead bits of the control byte
   task automatic t_ctrl();
      logic [4:0] dv [4] = '{5'h02, 5'h04, 5'h0A, 5'h14};
      rchk(8'h23, 8'h00, "pad1 routing");
      rchk(8'h24, 8'h00, "pad2 routing");
      rchk(8'h25, 8'h00, "filter control");
      for (int c = 0; c < 4; c++) begin
         host.wr(8'h25, {c[1:0], c[1:0], 4'hF});
         tick(1);
         `CHK("cutoff select", c[1:0], cutoff_select)
         `CHK("range select", c[1:0], range_select)
         `CHK("cutoff divider", dv[c], cutoff_div)
         `CHK("cutoff cap", (c == 0), cutoff_cap_400)
         `CHK("filter path", 1'b1, filter_path_select)
         `CHK("low noise", 1'b1, low_noise_en)
         rchk(8'h25, {c[1:0], c[1:0], 4'hC}, "filter control");
      end
      host.wr(8'h25, 8'h00);
      tick(1);
      `CHK("filter path", 1'b0, filter_path_select)
      `CHK("low noise", 1'b0, low_noise_en)
      `CHK("cutoff cap", 1'b1, cutoff_cap_400)
      @(posedge clk);
      lv[3] <= 1'b0;
      tick(2);
      `CHK("cutoff cap", 1'b0, cutoff_cap_400)
   endtask : t_ctrl
   // latched flags clear on status read; pulsed ones are gone by then
   task automatic t_events();
      logic [7:0] st [5] = '{8'h04, 8'h08, 8'h10, 8'h40, 8'h02};
      @(posedge clk);
      event_latch_select <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         pulse(8'h01 << i);
         rchk(8'h27, st[i], "latched status");
         rchk(8'h27, 8'h00, "status after read");
      end
      @(posedge clk);
      event_latch_select <= 1'b0;
      pad_polarity_select <= 1'b1;
      tick(3);
      `CHK("idle pad one", 1'b1, event_pad_one)
      @(posedge clk);
      pad_polarity_select <= 1'b0;
      host.wr(8'h23, 8'h21);
      pulse(8'h08);
      tick(1);
      `CHK("pad one", 1'b1, event_pad_one)
      tick(1);
      `CHK("pad one", 1'b0, event_pad_one)
      rchk(8'h27, 8'h00, "pulsed status");
      host.wr(8'h24, 8'hA0);
      @(posedge clk);
      lv[0] <= 1'b1;
      tick(3);
      `CHK("pad two", 1'b1, event_pad_two)
      rchk(8'h27, 8'h20, "sleep status");
      @(posedge clk);
      lv[0] <= 1'b0;
      lv[1] <= 1'b1;
      queue_fill <= 6'h05;
      queue_threshold <= 5'h05;
      rchk(8'h27, 8'h80, "level flag");
      @(posedge clk);
      queue_fill <= 6'h04;
      rchk(8'h27, 8'h00, "level flag");
      `CHK("pad two boot", 1'b1, event_pad_two)
   endtask : t_events
   // axis bytes, masking, coherent hold, temperature and refused places
   task automatic t_data();
      smp(16'hA5C7, 16'h3B6E);
      rchk(8'h27, 8'h01, "newdata flag");
      `CHK("pad one newdata", 1'b1, event_pad_one)
      rchk(8'h28, 8'hC4, "x low");
      rchk(8'h29, 8'hA5, "x high");
      rchk(8'h27, 8'h00, "newdata cleared");
      @(posedge clk);
      low_power_one <= 1'b1;
      word_coherent_update <= 1'b1;
      rchk(8'h2A, 8'h60, "y low masked");
      smp(16'h7F00, 16'h7F00);
      rchk(8'h2B, 8'h3B, "y high frozen");
      smp(16'h8100, 16'h8100);
      rchk(8'h2B, 8'h81, "y high new");
      @(posedge clk);
      temp_sample <= 8'hE7;
      pulse(8'h80);
      rchk(8'h26, 8'hE7, "temperature");
      host.wr(8'h26, 8'h00);
      rchk(8'h26, 8'hE7, "temperature");
      rchk(8'h40, 8'h00, "unmapped");
   endtask : t_data
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      srst = 1'b1;
      {ev, sample_valid, temp_sample, sample_x, sample_y} = '0;
      {word_coherent_update, event_latch_select, pad_polarity_select} = 3'b000;
      low_power_one = 1'b0;
      lv = 4'b1000;
      queue_fill = 6'h00;
      queue_threshold = 5'h1F;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      t_ctrl();
      t_events();
      t_data();
      print_verdict();
   end
endmodule : accirq_regs_tb_top
